// file: design/bst_pkg.sv
/*
  Constants, carrier structs and decode helpers for the boundary scan test port.
  Assumes one test port instance per chip, a test controller driving the
  test clock, and a core that runs on the system clock.
*/
// Summary of operation
// - Every primary input and output has a scan cell, chained into one register.
// - Scan register captures pad states and sets the value driven onto pads.
// - Outside scan mode and high impedance cells are transparent; core connects straight to pads.
// - In scan mode the core outputs are cut off and pads follow the test port; core inputs are cut off only in internal test.
// - Bypass instruction links serial in to serial out through one stage.
// - Sample instruction snapshots pad values while the chip runs normally.
// - Preload shifts data into the scan register without disturbing the pads.
// - External test drives the preloaded scan register contents onto the pads.
// - Internal test applies preloaded scan contents to the core inputs.
// - Self-test instruction starts a self-contained test of the chip.
// - Clamp holds preloaded values on pads and routes serial data via bypass.
// - Identification instruction puts the device id register in the serial path.
// - User code instruction gives a serially readable and writable id register.
// - High-impedance instruction turns every pad driver off.
// - Port has test clock, mode select, serial in, serial out, optional reset.
// - The test clock times the controller and the scan registers; the pad and core muxes run on the system clock.
// - Mode select sampled on each rising test clock edge picks the next state.
// - Serial data in shifts into the selected instruction or data register.
// - Selected register contents shift out on the serial data output.
// - Test reset low initialises the test logic asynchronously.
package bst_pkg;

  localparam int N_IN    = 4;
  localparam int N_OUT   = 4;
  localparam int BSR_LEN = N_IN + 2 * N_OUT;
  localparam int IR_LEN  = 4;
  localparam int ID_LEN  = 32;

  localparam logic [IR_LEN-1:0] IR_EXTEST   = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE   = 4'h1;
  localparam logic [IR_LEN-1:0] IR_PRELOAD  = 4'h2;
  localparam logic [IR_LEN-1:0] IR_INTEST   = 4'h3;
  localparam logic [IR_LEN-1:0] IR_RUNBIST  = 4'h4;
  localparam logic [IR_LEN-1:0] IR_CLAMP    = 4'h5;
  localparam logic [IR_LEN-1:0] IR_IDCODE   = 4'h6;
  localparam logic [IR_LEN-1:0] IR_USERCODE = 4'h7;
  localparam logic [IR_LEN-1:0] IR_HIGHZ    = 4'h8;
  localparam logic [IR_LEN-1:0] IR_BYPASS   = 4'hf;

  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
  localparam logic [ID_LEN-1:0] USER_RESET = 32'h0000_0000;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } bst_tap_st_t;

  typedef enum logic [1:0] {
    DR_BYP  = 2'h0,
    DR_BSR  = 2'h1,
    DR_WORD = 2'h2,
    DR_BIST = 2'h3
  } bst_dr_t;

  typedef struct packed {
    logic ext;
    logic intest;
    logic hiz;
    logic bist;
  } bst_mode_t;

  // Field order matches the scan chain: pad inputs sit next to serial out
  typedef struct packed {
    logic [N_OUT-1:0] coe;
    logic [N_OUT-1:0] cout;
    logic [N_IN-1:0]  pin;
  } bst_snap_t;

  typedef struct packed {
    bst_tap_st_t       state;
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    bst_mode_t         mode;
    bst_snap_t         bsr_sh;
    bst_snap_t         bsr_upd;
    logic              upd_tog;
    logic              byp;
    logic [ID_LEN-1:0] word_sh;
    logic [ID_LEN-1:0] user;
    logic              bist_sh;
    bst_snap_t         snap1;
    bst_snap_t         snap2;
    logic [1:0]        res1;
    logic [1:0]        res2;
  } bst_tck_st_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_neg_st_t;

  typedef struct packed {
    logic [N_IN-1:0]  pin1;
    logic [N_IN-1:0]  pin2;
    bst_snap_t        snap;
    logic [1:0]       res;
    logic [2:0]       tog;
    logic [1:0]       trst_n_sync;
    bst_mode_t        mode2;
    bst_snap_t        upd2;
    logic [N_OUT-1:0] pad_out;
    logic [N_OUT-1:0] pad_oe;
    logic [N_IN-1:0]  core_in;
    logic             bist_run;
  } bst_sys_st_t;

  localparam bst_mode_t   MODE_IDLE = '0;
  localparam bst_tck_st_t TCK_RESET = '{state: TAP_RESET, ir: IR_IDCODE,
                                        user: USER_RESET, default: '0};
  localparam bst_neg_st_t NEG_RESET = '0;
  localparam bst_sys_st_t SYS_RESET = '0;

  function automatic bst_tap_st_t bst_next(input bst_tap_st_t st, input logic tms);
    bst_tap_st_t n;
    n = TAP_RESET;
    case (st)
      TAP_RESET:  n = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: n = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: n = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    n = TAP_RESET;
    endcase
    return n;
  endfunction

  function automatic bst_mode_t bst_decode(input logic [IR_LEN-1:0] ir);
    bst_mode_t m;
    m = MODE_IDLE;
    case (ir)
      IR_EXTEST:  m.ext = 1'b1;
      IR_CLAMP:   m.ext = 1'b1;
      IR_INTEST:  m = '{ext: 1'b1, intest: 1'b1, default: 1'b0};
      IR_RUNBIST: m = '{ext: 1'b1, bist: 1'b1, default: 1'b0};
      IR_HIGHZ:   m.hiz = 1'b1;
      default:    m = MODE_IDLE;
    endcase
    return m;
  endfunction

  function automatic bst_dr_t bst_dr_sel(input logic [IR_LEN-1:0] ir);
    bst_dr_t d;
    d = DR_BYP;
    case (ir)
      IR_EXTEST, IR_SAMPLE, IR_PRELOAD, IR_INTEST: d = DR_BSR;
      IR_IDCODE, IR_USERCODE:                      d = DR_WORD;
      IR_RUNBIST:                                  d = DR_BIST;
      default:                                     d = DR_BYP;
    endcase
    return d;
  endfunction

endpackage

// file: design/bst_tap.sv
/*
  Boundary scan test port: state controller, instruction and data registers
  on the test clock, and the pad and core muxes on the system clock.
  Assumes pads are asynchronous to both clocks and the test clock runs
  only while the controller is working the port.
*/
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  // Arbitrary neutral identification value; bit 0 set as customary
  parameter logic [31:0] ID_VALUE = 32'h0000_0001
)
(
  // System clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       srst_in,
  // Test access port
  input  wire logic                       tck_in,
  input  wire logic                       trst_n_in,
  input  wire logic                       tms_in,
  input  wire logic                       tdi_in,
  output logic                            tdo_out,
  output logic                            tdo_oe_out,
  // Pads
  input  wire logic [bst_pkg::N_IN-1:0]   pad_in_in,
  output logic      [bst_pkg::N_OUT-1:0]  pad_out_out,
  output logic      [bst_pkg::N_OUT-1:0]  pad_oe_out,
  // Core
  output logic      [bst_pkg::N_IN-1:0]   core_in_out,
  input  wire logic [bst_pkg::N_OUT-1:0]  core_out_in,
  input  wire logic [bst_pkg::N_OUT-1:0]  core_oe_in,
  output logic                            bist_run_out,
  input  wire logic                       bist_done_in,
  input  wire logic                       bist_pass_in
);
  import bst_pkg::*;

  bst_tck_st_t t;
  bst_tck_st_t next_t;
  bst_neg_st_t n;
  bst_neg_st_t next_n;
  bst_sys_st_t s;
  bst_sys_st_t next_s;
  bst_dr_t     dr_sel;

  assign dr_sel = bst_dr_sel(t.ir);

  // Test clock domain
  always_comb
  begin
    next_t = t;
    // Pad and core snapshot crosses bit by bit as levels
    next_t.snap1 = s.snap;
    next_t.snap2 = t.snap1;
    next_t.res1  = s.res;
    next_t.res2  = t.res1;
    next_t.state = bst_next(t.state, tms_in);
    case (t.state)
      TAP_RESET:
      begin
        next_t.ir   = IR_IDCODE;
        next_t.mode = bst_decode(IR_IDCODE);
      end
      TAP_CAP_IR:
        next_t.ir_sh = IR_CAPTURE;
      TAP_SH_IR:
        next_t.ir_sh = {tdi_in, t.ir_sh[IR_LEN-1:1]};
      TAP_UPD_IR:
      begin
        next_t.ir   = t.ir_sh;
        next_t.mode = bst_decode(t.ir_sh);
      end
      TAP_CAP_DR:
      begin
        case (dr_sel)
          DR_BSR:
            next_t.bsr_sh = t.snap2;
          DR_WORD:
            next_t.word_sh = (t.ir == IR_IDCODE) ? ID_VALUE : t.user;
          DR_BIST:
            next_t.bist_sh = t.res2[1] & t.res2[0];
          default:
            next_t.byp = 1'b0;
        endcase
      end
      TAP_SH_DR:
      begin
        case (dr_sel)
          DR_BSR:
            next_t.bsr_sh = {tdi_in, t.bsr_sh[BSR_LEN-1:1]};
          DR_WORD:
            next_t.word_sh = {tdi_in, t.word_sh[ID_LEN-1:1]};
          DR_BIST:
            next_t.bist_sh = tdi_in;
          default:
            next_t.byp = tdi_in;
        endcase
      end
      TAP_UPD_DR:
      begin
        // Sample shares the update so a sample can double as a preload
        if (dr_sel == DR_BSR)
          next_t.bsr_upd = t.bsr_sh;
        if (t.ir == IR_USERCODE)
          next_t.user = t.word_sh;
      end
      default:
        next_t.ir_sh = t.ir_sh;
    endcase
    // Toggle once per change of mode or update word; the system side copies
    // the word only after it has seen the toggle or during a test reset, so no bit is caught mid-skew
    next_t.upd_tog = t.upd_tog ^ ((next_t.mode != t.mode)
                                  || (next_t.bsr_upd != t.bsr_upd));
  end

  always_ff @(posedge tck_in or negedge trst_n_in)
  begin
    if (!trst_n_in)
      t <= TCK_RESET;
    else
      t <= next_t;
  end

  // Serial out is launched half a test clock ahead of the controller's sample
  always_comb
  begin
    next_n.tdo_oe = (t.state == TAP_SH_DR) || (t.state == TAP_SH_IR);
    next_n.tdo    = 1'b0;
    if (t.state == TAP_SH_IR)
      next_n.tdo = t.ir_sh[0];
    else if (t.state == TAP_SH_DR)
    begin
      case (dr_sel)
        DR_BSR:  next_n.tdo = t.bsr_sh[0];
        DR_WORD: next_n.tdo = t.word_sh[0];
        DR_BIST: next_n.tdo = t.bist_sh;
        default: next_n.tdo = t.byp;
      endcase
    end
  end

  always_ff @(negedge tck_in or negedge trst_n_in)
  begin
    if (!trst_n_in)
      n <= NEG_RESET;
    else
      n <= next_n;
  end

  assign tdo_out    = n.tdo;
  assign tdo_oe_out = n.tdo_oe;

  // System clock domain
  always_comb
  begin
    next_s = s;
    next_s.pin1 = pad_in_in;
    next_s.pin2 = s.pin1;
    next_s.snap = '{coe: core_oe_in, cout: core_out_in, pin: s.pin2};
    next_s.res  = {bist_done_in, bist_pass_in};
    // Only the toggle and the test reset are synchronised; mode and update
    // word are copied once the toggle has settled, when they hold still.
    // Limitation: updates must lie about four system clocks apart.
    next_s.tog         = {s.tog[1:0], t.upd_tog};
    next_s.trst_n_sync = {s.trst_n_sync[0], trst_n_in};
    if ((s.tog[2] != s.tog[1]) || !s.trst_n_sync[1])
    begin
      next_s.mode2 = t.mode;
      next_s.upd2  = t.bsr_upd;
    end
    next_s.pad_out = s.mode2.ext ? s.upd2.cout : core_out_in;
    if (s.mode2.hiz)
      next_s.pad_oe = '0;
    else
      next_s.pad_oe = s.mode2.ext ? s.upd2.coe : core_oe_in;
    next_s.core_in  = s.mode2.intest ? s.upd2.pin : s.pin2;
    next_s.bist_run = s.mode2.bist;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      s <= SYS_RESET;
    else
      s <= next_s;
  end

  assign pad_out_out  = s.pad_out;
  assign pad_oe_out   = s.pad_oe;
  assign core_in_out  = s.core_in;
  assign bist_run_out = s.bist_run;

  // Checks on the test clock side
  property p_five_ones;
    @(posedge tck_in) disable iff (!trst_n_in)
    tms_in [*5] |=> (t.state == TAP_RESET);
  endproperty
  a_five_ones: assert property (p_five_ones)
    else $error("five high mode selects did not reach reset");

  property p_idle_step;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_IDLE) && tms_in |=> (t.state == TAP_SEL_DR);
  endproperty
  a_idle_step: assert property (p_idle_step)
    else $error("idle with mode select high did not go to select");

  property p_trst;
    @(posedge tck_in)
    !trst_n_in |-> (t.state == TAP_RESET) && (t.ir == IR_IDCODE) && !tdo_oe_out;
  endproperty
  a_trst: assert property (p_trst)
    else $error("test reset did not initialise the controller");

  property p_bypass;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_SH_DR) && (dr_sel == DR_BYP) ##1 (t.state == TAP_SH_DR)
      |-> (t.byp == $past(tdi_in)) && (tdo_out == t.byp);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass stage did not carry serial data");

  property p_tdo_idle;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state != TAP_SH_DR) && (t.state != TAP_SH_IR) |-> !tdo_oe_out;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle)
    else $error("serial out driven outside a shift");

  property p_tdo_ir;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_SH_IR) |-> tdo_oe_out && (tdo_out == t.ir_sh[0]);
  endproperty
  a_tdo_ir: assert property (p_tdo_ir)
    else $error("serial out does not show instruction bit");

  property p_idcode;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_CAP_DR) && (t.ir == IR_IDCODE) |=> (t.word_sh == ID_VALUE);
  endproperty
  a_idcode: assert property (p_idcode)
    else $error("identification value not captured");

  property p_usercode;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_UPD_DR) && (t.ir == IR_USERCODE) |=> (t.user == $past(t.word_sh));
  endproperty
  a_usercode: assert property (p_usercode)
    else $error("user code not written");

  property p_sample;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_CAP_DR) && (t.ir == IR_SAMPLE)
      |=> (t.bsr_sh == $past(t.snap2)) && !t.mode.ext && !t.mode.hiz;
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample did not capture pad snapshot");

  property p_preload;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.ir == IR_PRELOAD) |-> (t.mode == MODE_IDLE);
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload disturbs the pads");

  property p_ir_capture;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_CAP_IR) |=> (t.ir_sh == IR_CAPTURE);
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("instruction capture value not loaded");

  property p_ir_update;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_UPD_IR) |=> (t.ir == $past(t.ir_sh));
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction not taken from the shift stage");

  property p_bsr_shift;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_SH_DR) && (dr_sel == DR_BSR)
      |=> (t.bsr_sh == {$past(tdi_in), $past(t.bsr_sh[BSR_LEN-1:1])});
  endproperty
  a_bsr_shift: assert property (p_bsr_shift)
    else $error("scan chain did not shift by one cell");

  property p_tdo_dr;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_SH_DR) && (dr_sel == DR_WORD) |-> tdo_oe_out && (tdo_out == t.word_sh[0]);
  endproperty
  a_tdo_dr: assert property (p_tdo_dr)
    else $error("serial out does not show id word bit");

  property p_tdo_bsr;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_SH_DR) && (dr_sel == DR_BSR) |-> tdo_oe_out && (tdo_out == t.bsr_sh[0]);
  endproperty
  a_tdo_bsr: assert property (p_tdo_bsr)
    else $error("serial out does not show scan chain bit");

  property p_bist_cap;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_CAP_DR) && (dr_sel == DR_BIST)
      |=> (t.bist_sh == ($past(t.res2[1]) & $past(t.res2[0])));
  endproperty
  a_bist_cap: assert property (p_bist_cap)
    else $error("self test result not captured");

  property p_update_dr;
    @(posedge tck_in) disable iff (!trst_n_in)
    (t.state == TAP_UPD_DR) && (dr_sel == DR_BSR) |=> (t.bsr_upd == $past(t.bsr_sh));
  endproperty
  a_update_dr: assert property (p_update_dr)
    else $error("update register not loaded from the chain");

  // Checks on the system clock side
  property p_extest;
    @(posedge clk_sys_in) disable iff (srst_in)
    s.mode2.ext && !s.mode2.hiz
      |=> (pad_out_out == $past(s.upd2.cout)) && (pad_oe_out == $past(s.upd2.coe));
  endproperty
  a_extest: assert property (p_extest)
    else $error("pads do not follow the update register");

  property p_normal;
    @(posedge clk_sys_in) disable iff (srst_in)
    !s.mode2.ext && !s.mode2.hiz && !s.mode2.intest
      |=> (pad_out_out == $past(core_out_in)) && (pad_oe_out == $past(core_oe_in))
          && (core_in_out == $past(s.pin2));
  endproperty
  a_normal: assert property (p_normal)
    else $error("cells not transparent in normal mode");

  property p_intest;
    @(posedge clk_sys_in) disable iff (srst_in)
    s.mode2.intest |=> (core_in_out == $past(s.upd2.pin));
  endproperty
  a_intest: assert property (p_intest)
    else $error("core inputs do not follow the update register");

  property p_highz;
    @(posedge clk_sys_in) disable iff (srst_in)
    s.mode2.hiz |=> (pad_oe_out == '0);
  endproperty
  a_highz: assert property (p_highz)
    else $error("pad driver on in high impedance mode");

  property p_bist;
    @(posedge clk_sys_in) disable iff (srst_in)
    s.mode2.bist |=> bist_run_out ##1 (bist_run_out || !s.mode2.bist);
  endproperty
  a_bist: assert property (p_bist)
    else $error("self test not started");

  property p_mode_cross;
    @(posedge clk_sys_in) disable iff (srst_in)
    (s.tog[2] != s.tog[1]) |=> (s.mode2 == $past(t.mode)) && (s.upd2 == $past(t.bsr_upd));
  endproperty
  a_mode_cross: assert property (p_mode_cross)
    else $error("mode or update word not taken after the toggle");

  property p_highz_out;
    @(posedge clk_sys_in) disable iff (srst_in)
    s.mode2.hiz |=> (pad_out_out == $past(core_out_in));
  endproperty
  a_highz_out: assert property (p_highz_out)
    else $error("pad values do not follow the core in high impedance mode");

  property p_trst_pads;
    @(posedge clk_sys_in) disable iff (srst_in)
    !s.trst_n_sync[1] |=> (s.mode2 == MODE_IDLE);
  endproperty
  a_trst_pads: assert property (p_trst_pads)
    else $error("test reset did not return the pads to the core");

endmodule

// file: verif/bst_ctl_model.sv
/*
  Behavioural test controller that works the scan port of bst_tap.
  Assumes the bench calls its tasks one at a time; the test clock
  only runs inside those tasks and stands low between them.
*/
`timescale 1ns/1ps
module bst_ctl_model
(
  // Scan port, controller side
  output logic      tck_out,
  output logic      trst_n_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  wire logic tdo_line;

  // A released serial output reads as the inverse of its last level
  assign tdo_line = tdo_oe_in ? tdo_in : ~tdo_in;

  initial
  begin
    tck_out = 1'b0;
    trst_n_out = 1'b1;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  task automatic step(input logic t, input logic d, output logic o);
    tms_out = t;
    tdi_out = d;
    #15;
    o = tdo_line;
    tck_out = 1'b1;
    #15;
    tck_out = 1'b0;
  endtask

  // Clock runs through the reset so the port can be seen held there
  task automatic reset_port();
    logic o;
    trst_n_out = 1'b0;
    repeat (2) step(1'b1, ~tdi_out, o);
    trst_n_out = 1'b1;
    step(1'b0, ~tdi_out, o);
  endtask

  task automatic idle(input int n);
    logic o;
    repeat (n) step(1'b0, ~tdi_out, o);
  endtask

  // Idle to idle; serial data not shifted toggles every cycle
  task automatic scan(input logic is_ir, input int len, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi_out, o);
    if (is_ir)
      step(1'b1, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
    for (int i = 0; i < len; i++)
    begin
      step(i == len - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
  endtask
endmodule

// file: verif/test_boundary_scan_tap.sv
/*
  Self-checking bench for bst_tap: a controller model works the scan
  port while the bench drives pads and core and predicts every result.
  Assumes bypass captures 0 and pads settle within six system clocks.
*/
`timescale 1ns/1ps
module test_boundary_scan_tap;
  import bst_pkg::*;
  // Arbitrary identification value
  localparam logic [31:0] ID_TB = 32'h1234_5679;
  logic                 clk_sys_in = 1'b0;
  logic                 srst_in = 1'b1;
  logic [N_IN-1:0]      pad_in_in = '0;
  logic [N_OUT-1:0]     core_out_in = '0;
  logic [N_OUT-1:0]     core_oe_in = '0;
  logic                 bist_done_in = 1'b0;
  logic                 bist_pass_in = 1'b0;
  wire logic            tck, trst_n, tms, tdi, tdo, tdo_oe, bist_run;
  wire logic [N_OUT-1:0] pad_out, pad_oe;
  wire logic [N_IN-1:0] core_in;
  int                   errors = 0;
  int                   checked = 0;
  logic [31:0]          got, v;
  logic [31:0]          m_user = '0;
  logic [11:0]          m_upd, cur;
  logic                 q[$];
  logic [3:0]           codes[3] = '{IR_CLAMP, IR_BYPASS, 4'h9};

  bst_ctl_model u_ctl (.tck_out(tck), .trst_n_out(trst_n), .tms_out(tms), .tdi_out(tdi),
                       .tdo_in(tdo), .tdo_oe_in(tdo_oe));
  bst_tap #(.ID_VALUE(ID_TB)) u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .tck_in(tck), .trst_n_in(trst_n), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_out(tdo_oe), .pad_in_in(pad_in_in), .pad_out_out(pad_out),
    .pad_oe_out(pad_oe), .core_in_out(core_in), .core_out_in(core_out_in),
    .core_oe_in(core_oe_in), .bist_run_out(bist_run), .bist_done_in(bist_done_in),
    .bist_pass_in(bist_pass_in));

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic ir(input logic [3:0] c);
    u_ctl.scan(1'b1, 4, {28'h0, c}, got);
    chk("ir capture", got, IR_CAPTURE);
    repeat (6) @(posedge clk_sys_in);
    #1;
    chk("tdo released", tdo_oe, 1'b0);
  endtask

  task automatic drive_core(input logic [11:0] x);
    @(posedge clk_sys_in);
    pad_in_in <= x[3:0];
    core_out_in <= x[7:4];
    core_oe_in <= x[11:8];
    cur = x;
    repeat (6) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic pads(input string name, input logic [11:0] e);
    #1;
    chk({name, " out"}, pad_out, e[7:4]);
    chk({name, " oe"}, pad_oe, e[11:8]);
  endtask

  // Expected bypass stream: a one-stage delay line seeded with 0
  task automatic bypass_chk();
    logic [31:0] d;
    logic [31:0] e;
    d = $urandom;
    e = '0;
    q = {1'b0};
    for (int i = 0; i < 8; i++)
    begin
      q.push_back(d[i]);
      e[i] = q.pop_front();
    end
    u_ctl.scan(1'b0, 8, d, got);
    chk("bypass", got, e);
  endtask

  initial
  begin
    #2_000_000;
    errors++;
    $display("Watchdog expired");
    give_verdict();
  end

  initial
  begin
    void'($urandom(56833));
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    u_ctl.reset_port();
    v = $urandom;
    drive_core(v[11:0]);
    pads("normal", cur);
    chk("core in", core_in, cur[3:0]);
    u_ctl.scan(1'b0, 32, v, got);
    chk("idcode", got, ID_TB);
    $display("Test normal and id done");
    ir(IR_PRELOAD);
    m_upd = 12'($urandom);
    u_ctl.scan(1'b0, 12, {20'h0, m_upd}, got);
    repeat (6) @(posedge clk_sys_in);
    pads("preload", cur);
    ir(IR_SAMPLE);
    drive_core(12'($urandom));
    u_ctl.idle(6);
    u_ctl.scan(1'b0, 12, {20'h0, m_upd}, got);
    chk("sample", got, cur);
    $display("Test preload and sample done");
    ir(IR_EXTEST);
    pads("extest", m_upd);
    drive_core(12'($urandom));
    pads("isolated", m_upd);
    m_upd = 12'($urandom);
    u_ctl.scan(1'b0, 12, {20'h0, m_upd}, got);
    repeat (6) @(posedge clk_sys_in);
    pads("extest set", m_upd);
    ir(IR_INTEST);
    chk("intest core", core_in, m_upd[3:0]);
    $display("Test extest and intest done");
    foreach (codes[i])
    begin
      ir(codes[i]);
      pads("hold", codes[i] == IR_CLAMP ? m_upd : cur);
      bypass_chk();
    end
    ir(IR_HIGHZ);
    chk("highz oe", pad_oe, 4'h0);
    $display("Test bypass, clamp and highz done");
    @(posedge clk_sys_in);
    bist_done_in <= 1'b1;
    bist_pass_in <= 1'($urandom);
    ir(IR_RUNBIST);
    chk("bist run", bist_run, 1'b1);
    u_ctl.idle(6);
    u_ctl.scan(1'b0, 1, 32'h0, got);
    chk("bist result", got, {31'h0, bist_pass_in});
    ir(IR_USERCODE);
    chk("bist stop", bist_run, 1'b0);
    v = $urandom;
    u_ctl.scan(1'b0, 32, v, got);
    chk("user reset", got, m_user);
    m_user = v;
    u_ctl.scan(1'b0, 32, ~v, got);
    chk("user write", got, m_user);
    $display("Test self-test and user word done");
    ir(IR_BYPASS);
    u_ctl.idle(1);
    for (int i = 0; i < 5; i++)
      u_ctl.step(1'b1, 1'b0, got[0]);
    u_ctl.idle(1);
    u_ctl.scan(1'b0, 32, 32'h0, got);
    chk("tms reset id", got, ID_TB);
    ir(IR_USERCODE);
    u_ctl.reset_port();
    u_ctl.scan(1'b0, 32, 32'h0, got);
    chk("trst id", got, ID_TB);
    $display("Test controller resets done");
    give_verdict();
  end
endmodule
